//--- clm_asserts.sv
/*
 * Port checker for the companion link master.
 * Bound by the testbench; sees only the top module ports.
 */
`timescale 1ns/100ps
`default_nettype none

module clm_asserts (
  input wire logic        sys_clk_i,         // Clock
  input wire logic        srst_i,            // Reset
  input wire logic [7:0]  reg_addr_i,        // Address
  input wire logic [31:0] reg_wdata_i,       // Write data
  input wire logic        reg_wr_i,          // Write strobe
  input wire logic        reg_rd_i,          // Read strobe
  input wire logic [31:0] reg_rdata_o,       // Read data
  input wire logic        link_clock_out_o,  // Link clock
  input wire logic        link_data_io_i,    // Line level
  input wire logic        link_data_io_o,    // Drive value
  input wire logic        link_data_io_oe_o, // Drive enable
  input wire logic        done_irq_o,        // Done pulse
  input wire logic        error_irq_o,       // Error level
  input wire logic        sleep_inhibit_o    // Sleep hold
);
  // ******************************
  // Sequences and properties
  // ******************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // Two idle cycles in a row
  sequence s_idle2;
    !sleep_inhibit_o ##1 !sleep_inhibit_o;
  endsequence

  // Data write taken while idle
  sequence s_launch;
    reg_wr_i && reg_addr_i == clm_pkg::OFS_DATA && !sleep_inhibit_o;
  endsequence

  chk_reset_state: assert property (
    $fell(srst_i) |-> sleep_inhibit_o && !link_clock_out_o && !link_data_io_oe_o)
    else $error("bad state after reset");
  chk_idle_link: assert property (
    s_idle2 |-> !link_clock_out_o && !link_data_io_oe_o)
    else $error("link active while idle");
  chk_done_pulse: assert property (
    done_irq_o |-> !sleep_inhibit_o ##1 !done_irq_o)
    else $error("done pulse wrong");
  chk_status_read: assert property (
    reg_rd_i && reg_addr_i == clm_pkg::OFS_STATUS |=> reg_rdata_o[0] == $past(sleep_inhibit_o)
      && reg_rdata_o[3:1] == 3'h0 && reg_rdata_o[31:8] == 24'h0)
    else $error("status read wrong");
  chk_rdata_hold: assert property (
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  chk_launch_frame: assert property (
    s_launch |=> sleep_inhibit_o && link_data_io_oe_o && link_data_io_o)
    else $error("launch missing");
  chk_irq_off: assert property (
    reg_wr_i && reg_addr_i == clm_pkg::OFS_STATUS && !reg_wdata_i[clm_pkg::ST_ERR_EN] |-> ##2 !error_irq_o)
    else $error("error request not masked");
  chk_err_rise: assert property (
    $rose(error_irq_o) |-> $past(reg_wr_i, 2) || $past(sleep_inhibit_o, 2))
    else $error("error request rose unprompted");
endmodule

`default_nettype wire

//--- clm_companion_link_master.sv
/*
 * Companion link master: register port for firmware, a divided link
 * clock output and a shared data line toward one companion chip.
 * Assumes the companion answers each request after the turnaround
 * and that the data line carries a weak pull-up.
 */
// The implementer's own choice: the address-and-strobe port.
// Overview of operation
// - All logic and the link clock come from one system clock.
// - System reset returns every register and state to default.
// - Completion interrupt raised when hardware clears busy.
// - Error interrupt follows the error flag gated by its enable.
// - Idle with busy low; divider stopped, sleep never held off.
// - Sleep inhibit stays asserted while the engine is not idle.
// - First data read launches link read and sets busy; value stale.
// - Next data read after busy clears returns the received byte.
// - Bad or missing read response times out and flags an error.
// - Read response loads data, raises completion, clears busy.
// - Data write launches write packet with address and byte, sets busy.
// - No answer in 16 link clocks; error 48 clocks later, busy clears.
// - Write acknowledge raises completion and clears busy.
// - Registers at 00h, 04h, 08h and 0Ch.
// - Reset bit holds link in reset; busy until 48 clocks after.
// - Busy clearing after soft reset raises no completion interrupt.
// - Error flag set as busy clears; cleared by writing one.
// - Link clock rate set by the clock select register.
`timescale 1ns/100ps
`default_nettype none

module clm_companion_link_master (
  input  wire logic        sys_clk_i,         // System clock
  input  wire logic        srst_i,            // Synchronous reset, high
  input  wire logic [7:0]  reg_addr_i,        // Register byte address
  input  wire logic [31:0] reg_wdata_i,       // Register write data
  input  wire logic        reg_wr_i,          // Write strobe
  input  wire logic        reg_rd_i,          // Read strobe
  output logic      [31:0] reg_rdata_o,       // Read data, next cycle
  output logic             link_clock_out_o,  // Link clock to companion
  input  wire logic        link_data_io_i,    // Data line level
  output logic             link_data_io_o,    // Data line drive value
  output logic             link_data_io_oe_o, // Data line drive enable
  output logic             done_irq_o,        // Completion pulse
  output logic             error_irq_o,       // Error request level
  output logic             sleep_inhibit_o    // Holds off chip sleep
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  clm_pkg::clm_state_t state_q;
  logic                reset_bit_q;
  logic                done_en_q;
  logic                err_en_q;
  logic                err_q;
  logic [7:0]          addr_q;
  logic [7:0]          data_q;
  logic [7:0]          div_q;
  logic                rd_pending_q;
  logic [7:0]          div_cnt_q;
  logic                phase_q;
  logic [clm_pkg::FRAME_BITS-1:0] tx_q;
  logic [clm_pkg::RESP_BITS-1:0]  rx_q;
  logic [4:0]          bit_cnt_q;
  logic [5:0]          clk_cnt_q;
  logic                oe_q;
  logic                din_meta_q;
  logic                din_q;
  logic                done_q;
  logic                err_irq_q;
  logic [31:0]         rdata_q;

  logic                sel_status;
  logic                sel_addr;
  logic                sel_data;
  logic                sel_div;
  logic                busy;
  logic                run;
  logic                tick;
  logic                rise_en;
  logic                fall_en;
  logic                last_rise;
  logic                launch_wr;
  logic                launch_rd;
  logic                hw_done;
  logic                hw_err;
  logic                resp_ok;
  logic [7:0]          req_crc;

  // ****************************************************************
  // CRC over the low len bits, msb first
  // ****************************************************************
  function automatic logic [7:0] crc8_f(input logic [16:0] bits, input int unsigned len);
    logic [7:0] c;
    logic       fb;
    c  = 8'h00;
    fb = 1'b0;
    for (int i = 16; i >= 0; i--)
    begin
      if (i < int'(len))
      begin
        fb = c[7] ^ bits[i];
        c  = {c[6:0], 1'b0} ^ (fb ? clm_pkg::CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction

  // ****************************************************************
  // Address decode and launch conditions
  // ****************************************************************
  // Register select
  assign sel_status = (reg_addr_i == clm_pkg::OFS_STATUS);
  assign sel_addr   = (reg_addr_i == clm_pkg::OFS_ADDRESS);
  assign sel_data   = (reg_addr_i == clm_pkg::OFS_DATA);
  assign sel_div    = (reg_addr_i == clm_pkg::OFS_CLKDIV);

  // Busy is any non-idle engine state
  assign busy      = (state_q != clm_pkg::CLM_IDLE);
  assign launch_wr = reg_wr_i && sel_data && !busy && !reset_bit_q;
  assign launch_rd = reg_rd_i && sel_data && !busy && !reset_bit_q && !rd_pending_q;
  assign req_crc   = crc8_f({launch_wr, addr_q, launch_wr ? reg_wdata_i[7:0] : 8'h00}, 17);
  assign resp_ok   = (crc8_f({9'h000, rx_q[15:8]}, 8) == rx_q[7:0]);

  // ****************************************************************
  // Link clock divider
  // ****************************************************************
  // Runs only while a transfer or reset count is in progress
  assign run     = busy && (state_q != clm_pkg::CLM_RST_HOLD);
  assign tick    = run && (div_cnt_q == div_q);
  assign rise_en = tick && !phase_q;
  assign fall_en = tick && phase_q;

  // Tick that ends a transfer or reset count; no stray pulse left behind
  assign last_rise = rise_en &&
                     (((state_q == clm_pkg::CLM_RECV) && (bit_cnt_q == 5'(clm_pkg::RESP_BITS))) ||
                      ((state_q == clm_pkg::CLM_HOLD) && (clk_cnt_q == clm_pkg::HOLDOFF_CLKS - 6'd1)) ||
                      ((state_q == clm_pkg::CLM_RST_CNT) && (clk_cnt_q == clm_pkg::RESET_CLKS - 6'd1)));

  // Half period counter and clock phase
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || !run)
    begin
      div_cnt_q <= 8'h00;
      phase_q   <= 1'b0;
    end
    else if (tick)
    begin
      div_cnt_q <= 8'h00;
      phase_q   <= !phase_q && !last_rise;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // Data line synchroniser
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      din_meta_q <= 1'b1;
      din_q      <= 1'b1;
    end
    else
    begin
      din_meta_q <= link_data_io_i;
      din_q      <= din_meta_q;
    end
  end

  // ****************************************************************
  // Link engine
  // ****************************************************************
  // Sequencing of request, turnaround, response and holdoffs
  always_ff @(posedge sys_clk_i)
  begin
    hw_done <= 1'b0;
    hw_err  <= 1'b0;
    if (srst_i)
    begin
      state_q   <= clm_pkg::CLM_RST_HOLD;
      tx_q      <= '0;
      rx_q      <= '0;
      bit_cnt_q <= 5'd0;
      clk_cnt_q <= 6'd0;
      oe_q      <= 1'b0;
      hw_done   <= 1'b0;
      hw_err    <= 1'b0;
    end
    else if (reset_bit_q && state_q != clm_pkg::CLM_RST_HOLD)
    begin
      state_q <= clm_pkg::CLM_RST_HOLD;
      oe_q    <= 1'b0;
    end
    else
    begin
      case (state_q)
        clm_pkg::CLM_IDLE:
        begin
          if (launch_wr || launch_rd)
          begin
            tx_q      <= {1'b1, launch_wr, addr_q, launch_wr ? reg_wdata_i[7:0] : 8'h00, req_crc};
            bit_cnt_q <= 5'd0;
            oe_q      <= 1'b1;
            state_q   <= clm_pkg::CLM_SEND;
          end
        end
        clm_pkg::CLM_SEND:
        begin
          if (fall_en)
          begin
            tx_q <= {tx_q[clm_pkg::FRAME_BITS-2:0], 1'b0};
          end
          if (rise_en)
          begin
            bit_cnt_q <= bit_cnt_q + 5'd1;
            if (bit_cnt_q == 5'(clm_pkg::FRAME_BITS - 1))
            begin
              // Last bit stays driven past the rise that samples it
              clk_cnt_q <= 6'd0;
              state_q   <= clm_pkg::CLM_TURN;
            end
          end
        end
        clm_pkg::CLM_TURN:
        begin
          // Release the line half a clock after the last request bit
          if (fall_en)
          begin
            oe_q <= 1'b0;
          end
          if (rise_en)
          begin
            clk_cnt_q <= clk_cnt_q + 6'd1;
            if (clk_cnt_q == clm_pkg::TAR_CLKS - 6'd1)
            begin
              clk_cnt_q <= 6'd0;
              state_q   <= clm_pkg::CLM_WAIT;
            end
          end
        end
        clm_pkg::CLM_WAIT:
        begin
          if (rise_en)
          begin
            // Start bit is low; a released line floats high
            if (!din_q)
            begin
              bit_cnt_q <= 5'd0;
              state_q   <= clm_pkg::CLM_RECV;
            end
            else if (clk_cnt_q == clm_pkg::TIMEOUT_CLKS - 6'd1)
            begin
              clk_cnt_q <= 6'd0;
              state_q   <= clm_pkg::CLM_HOLD;
            end
            else
            begin
              clk_cnt_q <= clk_cnt_q + 6'd1;
            end
          end
        end
        clm_pkg::CLM_RECV:
        begin
          if (rise_en)
          begin
            rx_q      <= {rx_q[clm_pkg::RESP_BITS-2:0], din_q};
            bit_cnt_q <= bit_cnt_q + 5'd1;
            if (bit_cnt_q == 5'(clm_pkg::RESP_BITS))
            begin
              // Last bit already in; crc decides the outcome
              if (resp_ok)
              begin
                hw_done <= 1'b1;
                state_q <= clm_pkg::CLM_IDLE;
              end
              else
              begin
                clk_cnt_q <= 6'd0;
                state_q   <= clm_pkg::CLM_HOLD;
              end
              rx_q <= rx_q;
            end
          end
        end
        clm_pkg::CLM_HOLD:
        begin
          if (rise_en)
          begin
            clk_cnt_q <= clk_cnt_q + 6'd1;
            if (clk_cnt_q == clm_pkg::HOLDOFF_CLKS - 6'd1)
            begin
              hw_done <= 1'b1;
              hw_err  <= 1'b1;
              state_q <= clm_pkg::CLM_IDLE;
            end
          end
        end
        clm_pkg::CLM_RST_HOLD:
        begin
          if (!reset_bit_q)
          begin
            clk_cnt_q <= 6'd0;
            state_q   <= clm_pkg::CLM_RST_CNT;
          end
        end
        clm_pkg::CLM_RST_CNT:
        begin
          if (rise_en)
          begin
            clk_cnt_q <= clk_cnt_q + 6'd1;
            if (clk_cnt_q == clm_pkg::RESET_CLKS - 6'd1)
            begin
              state_q <= clm_pkg::CLM_IDLE;
            end
          end
        end
        default:
        begin
          state_q <= clm_pkg::CLM_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Status control bits and error flag, set beats clear
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      reset_bit_q <= clm_pkg::RST_RESET_BIT;
      done_en_q   <= 1'b0;
      err_en_q    <= 1'b0;
      err_q       <= 1'b0;
    end
    else
    begin
      if (reg_wr_i && sel_status)
      begin
        reset_bit_q <= reg_wdata_i[clm_pkg::ST_RESET];
        done_en_q   <= reg_wdata_i[clm_pkg::ST_DONE_EN];
        err_en_q    <= reg_wdata_i[clm_pkg::ST_ERR_EN];
      end
      if (hw_err)
      begin
        err_q <= 1'b1;
      end
      else if (reg_wr_i && sel_status && reg_wdata_i[clm_pkg::ST_ERR])
      begin
        err_q <= 1'b0;
      end
    end
  end

  // Address, data and clock select
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      addr_q <= clm_pkg::RST_ADDRESS;
      data_q <= clm_pkg::RST_DATA;
      div_q  <= clm_pkg::RST_CLKDIV;
    end
    else
    begin
      if (reg_wr_i && sel_addr)
      begin
        addr_q <= reg_wdata_i[7:0];
      end
      if (launch_wr)
      begin
        data_q <= reg_wdata_i[7:0];
      end
      else if (hw_done && !hw_err && !tx_q[clm_pkg::FRAME_BITS-2] && rd_pending_q)
      begin
        data_q <= rx_q[15:8];
      end
      if (reg_wr_i && sel_div && !busy)
      begin
        div_q <= reg_wdata_i[7:0];
      end
    end
  end

  // Two-step read sequence tracking
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || reset_bit_q)
    begin
      rd_pending_q <= 1'b0;
    end
    else if (launch_rd)
    begin
      rd_pending_q <= 1'b1;
    end
    else if (reg_rd_i && sel_data && !busy)
    begin
      rd_pending_q <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (reg_rd_i)
    begin
      rdata_q <= 32'h0000_0000;
      if (sel_status)
      begin
        rdata_q[clm_pkg::ST_BUSY]    <= busy;
        rdata_q[clm_pkg::ST_DONE_EN] <= done_en_q;
        rdata_q[clm_pkg::ST_ERR_EN]  <= err_en_q;
        rdata_q[clm_pkg::ST_ERR]     <= err_q;
        rdata_q[clm_pkg::ST_RESET]   <= reset_bit_q;
      end
      else if (sel_addr)
      begin
        rdata_q[7:0] <= addr_q;
      end
      else if (sel_data)
      begin
        rdata_q[7:0] <= data_q;
      end
      else if (sel_div)
      begin
        rdata_q[7:0] <= div_q;
      end
    end
  end

  // ****************************************************************
  // Interrupt requests and sleep control
  // ****************************************************************
  // Completion pulse only on hardware clear, never after soft reset
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      done_q    <= 1'b0;
      err_irq_q <= 1'b0;
    end
    else
    begin
      done_q    <= hw_done && done_en_q;
      err_irq_q <= (err_q || hw_err) && err_en_q;
    end
  end

  // Output drive
  assign reg_rdata_o       = rdata_q;
  assign link_clock_out_o  = phase_q;
  assign link_data_io_o    = tx_q[clm_pkg::FRAME_BITS-1];
  assign link_data_io_oe_o = oe_q;
  assign done_irq_o        = done_q;
  assign error_irq_o       = err_irq_q;
  assign sleep_inhibit_o   = busy;

endmodule

`default_nettype wire

//--- clm_companion_link_master_tb_top.sv
/*
 * Top testbench of the companion link master.
 * Drives the register port; the line has a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none

module clm_companion_link_master_tb_top;
  localparam int HALF = 4; // Half period, select 3
  logic        sys_clk_i, srst_i, reg_wr_i, reg_rd_i;
  logic [7:0]  reg_addr_i, a, v;
  logic [31:0] reg_wdata_i, reg_rdata_o, d;
  logic        link_clock_out_o, link_data_io_o, link_data_io_oe_o;
  logic        done_irq_o, error_irq_o, sleep_inhibit_o;
  wire         link_data_io_i;
  logic        comp_drv, comp_oe, silent, bad_crc, sel_chk;
  logic [1:0]  delay;
  int          errors, total_checks, seed, n;
  int          done_cnt = 0;
  int          hi_n = 0;
  logic [31:0] rst_exp [5] = '{32'h81, 32'h0, 32'h0, 32'h2, 32'h0};

  clm_companion_link_master clm_companion_link_master_inst (
    .sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_clock_out_o,
    .link_data_io_i, .link_data_io_o, .link_data_io_oe_o, .done_irq_o, .error_irq_o, .sleep_inhibit_o
  );
  clm_companion_model clm_companion_model_inst (
    .link_clk_i(link_clock_out_o), .line_i(link_data_io_i), .master_oe_i(link_data_io_oe_o),
    .silent_i(silent), .bad_crc_i(bad_crc), .delay_i(delay), .drv_o(comp_drv), .oe_o(comp_oe)
  );
  // Pull-up wins when nobody drives
  assign link_data_io_i = link_data_io_oe_o ? link_data_io_o : (comp_oe ? comp_drv : 1'b1);

  // ******************************
  // Clock, monitors and tasks
  // ******************************
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Done pulses and link clock high time
  always @(posedge sys_clk_i)
  begin
    if (done_irq_o === 1'b1)
      done_cnt <= done_cnt + 1;
    if (link_clock_out_o === 1'b1)
      hi_n <= hi_n + 1;
    else
    begin
      if (hi_n != 0 && sel_chk)
        chk("half_period", 32'(HALF), 32'(hi_n));
      hi_n <= 0;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= wd;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 q = reg_rdata_o;
  endtask

  // Poll busy under a bound
  task automatic wait_idle();
    for (int k = 0; k < 1000; k++)
    begin
      rd(8'h00, d);
      if (d[0] === 1'b0)
      begin
        repeat (2) @(posedge sys_clk_i);
        return;
      end
    end
    chk("busy_wait", 32'h0, d);
    summarize();
  endtask

  // One link transfer with completion checks
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] wd, input logic e);
    int c;
    c = done_cnt;
    wr(8'h04, {24'h0, ad});
    rd(8'h04, d);
    chk("address", {24'h0, ad}, d);
    if (w)
    begin
      wr(8'h08, {24'h0, wd});
      wr(8'h08, {24'h0, ~wd}); // Ignored while busy
    end
    else
      rd(8'h08, d);
    wait_idle();
    chk("done_irq", 32'(c + 1), 32'(done_cnt));
    rd(8'h00, d);
    chk("error_flag", {31'h0, e}, {31'h0, d[6]});
  endtask

  // ******************************
  // Main sequence
  // ******************************
  initial
  begin
    srst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    silent = 1'b0;
    bad_crc = 1'b0;
    delay = 2'h0;
    sel_chk = 1'b0;
    seed = 32'hf8d2;
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      rd(8'(i * 4), d);
      chk("reset_value", rst_exp[i], d);
    end
    // Leave soft reset, junk in fixed bits
    n = done_cnt;
    wr(8'h00, 32'hffff_ff3f);
    wait_idle();
    rd(8'h00, d);
    chk("status", 32'h30, d);
    chk("reset_done_irq", 32'(n), 32'(done_cnt));
    wr(8'h0c, 32'h3);
    rd(8'h0c, d);
    chk("clock_select", 32'h3, d);
    sel_chk <= 1'b1;
    // Random write, then two-step read back
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 8'hff : 8'($random(seed));
      v = 8'($random(seed));
      delay <= 2'($random(seed));
      xfer(1'b1, a, v, 1'b0);
      chk("companion_reg", {24'h0, v}, {24'h0, clm_companion_model_inst.mem[a]});
      xfer(1'b0, a, 8'h00, 1'b0);
      rd(8'h08, d);
      chk("read_data", {24'h0, v}, d);
    end
    // Silent companion times out
    silent <= 1'b1;
    xfer(1'b1, 8'h3c, 8'ha5, 1'b1);
    chk("error_irq", 32'h1, {31'h0, error_irq_o});
    silent <= 1'b0;
    wr(8'h00, 32'h70);
    rd(8'h00, d);
    chk("error_clear", 32'h30, d);
    // Corrupt answer crc on a read
    bad_crc <= 1'b1;
    xfer(1'b0, a, 8'h00, 1'b1);
    bad_crc <= 1'b0;
    // Soft reset, then retry the read
    n = done_cnt;
    wr(8'h00, 32'hf0);
    rd(8'h00, d);
    chk("soft_reset", 32'hb1, d);
    wr(8'h00, 32'h30);
    wait_idle();
    chk("reset_done_irq", 32'(n), 32'(done_cnt));
    xfer(1'b0, a, 8'h00, 1'b0);
    rd(8'h08, d);
    chk("retry_data", {24'h0, v}, d);
    wr(8'h00, 32'h0);
    rd(8'h00, d);
    chk("irq_off", 32'h0, {d[31:1], error_irq_o});
    summarize();
  end
endmodule

bind clm_companion_link_master clm_asserts clm_asserts_inst (
  .sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_clock_out_o,
  .link_data_io_i, .link_data_io_o, .link_data_io_oe_o, .done_irq_o, .error_irq_o, .sleep_inhibit_o
);

`default_nettype wire

//--- clm_companion_model.sv
/*
 * Behavioural companion chip at the far end of the link.
 * Assumes the master drives on falling and samples on rising edges.
 */
`timescale 1ns/100ps
`default_nettype none

module clm_companion_model (
  input  wire logic       link_clk_i,  // Link clock
  input  wire logic       line_i,      // Resolved line
  input  wire logic       master_oe_i, // Master drives
  input  wire logic       silent_i,    // Never answer
  input  wire logic       bad_crc_i,   // Corrupt answer crc
  input  wire logic [1:0] delay_i,     // Extra answer delay
  output logic            drv_o,       // Drive value
  output logic            oe_o         // Drive enable
);
  logic [7:0]  mem [256];
  logic [24:0] sh;
  logic [16:0] rsp;

  // Crc8, poly 07, init 0, msb first
  function automatic logic [7:0] crc8(input logic [16:0] b, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int k = n - 1; k >= 0; k--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[k]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // ******************************
  // Request capture and answer
  // ******************************
  initial
  begin
    drv_o = 1'b0;
    oe_o = 1'b0;
    forever
    begin
      @(posedge link_clk_i iff (master_oe_i && line_i));
      for (int k = 0; k < 25; k++)
      begin
        @(posedge link_clk_i);
        sh = {sh[23:0], line_i};
      end
      // Bad request crc is dropped silently
      if (crc8(sh[24:8], 17) === sh[7:0] && !silent_i)
      begin
        if (sh[24])
          mem[sh[23:16]] = sh[15:8];
        rsp = {1'b0, mem[sh[23:16]], 8'h00}; // Low start bit against the pull-up
        rsp[7:0] = crc8({9'h0, rsp[15:8]}, 8) ^ {7'h0, bad_crc_i};
        repeat (3 + delay_i) @(negedge link_clk_i);
        oe_o = 1'b1;
        for (int k = 16; k >= 0; k--)
        begin
          drv_o = rsp[k];
          @(negedge link_clk_i);
        end
        oe_o = 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

//--- clm_pkg.sv
/*
 * Constants shared by the companion link master: register offsets,
 * status field positions, reset values and link timing counts.
 * Assumes a single system clock and a plain register port.
 */
`default_nettype none

package clm_pkg;

  // ****************************************************************
  // Clocking
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 20_000_000; // System clock rate
  localparam int unsigned SRC_CLK_MHZ   = 48;         // Nominal source clock

  // ****************************************************************
  // Register map (byte offsets)
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS     = 8'h00;
  localparam logic [7:0] OFS_ADDRESS    = 8'h04;
  localparam logic [7:0] OFS_DATA       = 8'h08;
  localparam logic [7:0] OFS_CLKDIV     = 8'h0c;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_DONE_EN    = 4;
  localparam int unsigned ST_ERR_EN     = 5;
  localparam int unsigned ST_ERR        = 6;
  localparam int unsigned ST_RESET      = 7;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic       RST_RESET_BIT  = 1'b1;
  localparam logic [7:0] RST_ADDRESS    = 8'h00;
  localparam logic [7:0] RST_DATA       = 8'h00;
  localparam logic [7:0] RST_CLKDIV     = 8'h02;

  // ****************************************************************
  // Link framing and timing, counted in link clocks
  // ****************************************************************
  localparam int unsigned FRAME_BITS    = 26;  // Start, rw, addr, data, crc
  localparam int unsigned RESP_BITS     = 16;  // Data and crc after start
  localparam logic [5:0]  TAR_CLKS      = 6'd2;
  localparam logic [5:0]  TIMEOUT_CLKS  = 6'd16;
  localparam logic [5:0]  HOLDOFF_CLKS  = 6'd48;
  localparam logic [5:0]  RESET_CLKS    = 6'd48;
  localparam logic [7:0]  CRC_POLY      = 8'h07;

  // Engine states
  typedef enum logic [2:0] {
    CLM_IDLE,
    CLM_SEND,
    CLM_TURN,
    CLM_WAIT,
    CLM_RECV,
    CLM_HOLD,
    CLM_RST_HOLD,
    CLM_RST_CNT
  } clm_state_t;

endpackage

`default_nettype wire
